// ==== rtl/feedback_scaler.sv ====
// Purpose: Scales a feedback sample by the digital gain over 1024.
// Assumes: One sample per valid pulse; gain is steady while in use.
// Notes:   One cycle of latency; the result saturates at the sample width.
`include "vout_sense_trim_regs.svh"
`timescale 1ns/10ps
module feedback_scaler (
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   input  wire logic                    sample_valid,
   input  wire logic [`SAMPLE_W-1:0]    sample,
   input  wire logic [`GAIN_W-1:0]      gain,
   output logic      [`SAMPLE_W-1:0]    scaled_q,
   output logic                         scaled_valid_q
);

   logic [`SAMPLE_W+`GAIN_W-1:0] product;
   logic [`SAMPLE_W+`GAIN_W-1:0] quotient;

   // Shifting right drops the fraction, truncating toward zero for an unsigned value.
   always_comb begin
      product  = {{`GAIN_W{1'b0}}, sample} * {{`SAMPLE_W{1'b0}}, gain};
      quotient = product >> `GAIN_SHIFT;
   end

   // Gains above unity could overflow the sample width; clamping avoids a wrap to small values.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         scaled_q       <= '0;
         scaled_valid_q <= 1'b0;
      end else begin
         scaled_valid_q <= sample_valid;
         if (sample_valid) begin
            if (|quotient[`SAMPLE_W+`GAIN_W-1:`SAMPLE_W]) begin
               scaled_q <= {`SAMPLE_W{1'b1}};
            end else begin
               scaled_q <= quotient[`SAMPLE_W-1:0];
            end
         end
      end
   end

endmodule

// ==== rtl/vout_sense_pkg.sv ====
// Purpose: Shared types of the output-voltage sense trim block.
// Assumes: Constants come from vout_sense_trim_regs.svh.
// Notes:   Nothing here is imported; users write the package name.
package vout_sense_pkg;

   // Legal protection margin codes; any other value is invalid.
   typedef enum logic [2:0] {
      margin_190 = 3'b001,
      margin_310 = 3'b010,
      margin_430 = 3'b100
   } margin_code_t;

   // Gain of the remote sense amplifier.
   typedef enum logic {
      amp_unity = 1'b0,
      amp_half  = 1'b1
   } amp_gain_t;

endpackage

// ==== rtl/vout_sense_trim_regs.sv ====
// Purpose: Trim registers for output-voltage sensing and secondary protection.
// Assumes: A serial management front end turns bus traffic into one-cycle
//          read and write strobes with a command code; inputs are synchronous.
// Notes:   Read data arrive one cycle after the strobe; every output is a flop.
`include "vout_sense_trim_regs.svh"
`timescale 1ns/10ps
module vout_sense_trim_regs (
   input  wire logic                          ref_clk,
   input  wire logic                          resetn,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   input  wire logic [7:0]                    cmd_code,
   input  wire logic [15:0]                   wr_data,
   input  wire logic                          sense_amp_gain_select,
   input  wire logic [`MV_W-1:0]              vref_mv,
   input  wire logic                          sample_valid,
   input  wire logic [`SAMPLE_W-1:0]          feedback_raw_sample,
   output logic      [15:0]                   rd_data_q,
   output logic                               rd_valid_q,
   output logic                               cmd_error_q,
   output logic      [`DROOP_TRIM_W-1:0]      droop_current_trim_q,
   output logic      [19:0]                   droop_offset_na_q,
   output logic      [`AMP_TRIM_W-1:0]        remote_amp_trim_q,
   output logic      [9:0]                    remote_amp_step_uv_q,
   output logic      [19:0]                   remote_amp_offset_uv_q,
   output logic      [`GAIN_W-1:0]            feedback_digital_gain_q,
   output logic      [`LEVEL_W-1:0]           protection_margin_level_q,
   output logic                               margin_code_invalid_q,
   output logic      [`MV_W-1:0]              secondary_overvoltage_limit_q,
   output logic      [`MV_W-1:0]              secondary_undervoltage_limit_q,
   output logic      [`SAMPLE_W-1:0]          scaled_feedback_value_q,
   output logic                               scaled_valid_q
);

   // Stored factory trims; written only by whatever the host sends.
   logic [`FTRIM_W-1:0] undervolt_factory_trim_q;
   logic [`FTRIM_W-1:0] overvolt_factory_trim_q;
   // Margin in effect, in millivolts; only ever holds a legal margin.
   logic [`MV_W-1:0]    margin_mv_q;
   logic [`MV_W-1:0]    margin_eff;
   logic [`MV_W:0]      margin_dec;
   logic [`MV_W:0]      ov_sum;
   logic [`MV_W-1:0]    uv_diff;
   logic                code_known;
   logic [15:0]         rd_word;
   logic                map_hit;
   logic signed [19:0]  droop_prod;
   logic signed [19:0]  amp_prod;
   logic [9:0]          amp_step;

   // Decodes a margin code; the flag reports whether the code is legal.
   function automatic logic [`MV_W:0] margin_decode(input logic [`LEVEL_W-1:0] code);
      logic [`MV_W:0] res;
      res = '0;
      unique case (code)
         `LEVEL_CODE_190: res = {1'b1, `MARGIN_190_MV};
         `LEVEL_CODE_310: res = {1'b1, `MARGIN_310_MV};
         `LEVEL_CODE_430: res = {1'b1, `MARGIN_430_MV};
         default:         res = '0;
      endcase
      return res;
   endfunction

   // Answers whether a command code addresses one of the four registers.
   function automatic logic is_mapped(input logic [7:0] code);
      return (code == `CMD_DROOP_OFFSET) || (code == `CMD_PROT_WINDOW) ||
             (code == `CMD_REMOTE_AMP_OFFSET) || (code == `CMD_FEEDBACK_GAIN);
   endfunction

   // Droop trim; the ten upper write bits have no storage and are dropped.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         droop_current_trim_q <= `DROOP_TRIM_RST;
      end else if (wr_en && cmd_code == `CMD_DROOP_OFFSET) begin
         droop_current_trim_q <= wr_data[`DROOP_TRIM_W-1:0];
      end
   end

   // Window register: level and the two factory trims.
   // The fixed-one bits have no storage, so writes to them cannot change them.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         protection_margin_level_q <= `LEVEL_RST;
         undervolt_factory_trim_q  <= `UV_TRIM_RST;
         overvolt_factory_trim_q   <= `OV_TRIM_RST;
      end else if (wr_en && cmd_code == `CMD_PROT_WINDOW) begin
         protection_margin_level_q <= wr_data[`LEVEL_LSB+:`LEVEL_W];
         // The host is expected to write back the trims it read first.
         undervolt_factory_trim_q  <= wr_data[`UV_TRIM_LSB+:`FTRIM_W];
         overvolt_factory_trim_q   <= wr_data[`OV_TRIM_LSB+:`FTRIM_W];
      end
   end

   // Remote amplifier trim; bits 15 to 7 of a write are discarded.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         remote_amp_trim_q <= `AMP_TRIM_RST;
      end else if (wr_en && cmd_code == `CMD_REMOTE_AMP_OFFSET) begin
         remote_amp_trim_q <= wr_data[`AMP_TRIM_W-1:0];
      end
   end

   // Feedback gain; comes up at unity.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         feedback_digital_gain_q <= `GAIN_RST;
      end else if (wr_en && cmd_code == `CMD_FEEDBACK_GAIN) begin
         feedback_digital_gain_q <= wr_data[`GAIN_W-1:0];
      end
   end

   // Read multiplexer; unused and unmapped positions return zero.
   always_comb begin
      rd_word = 16'h0000;
      map_hit = is_mapped(cmd_code);
      unique case (cmd_code)
         `CMD_DROOP_OFFSET: begin
            rd_word[`DROOP_TRIM_W-1:0] = droop_current_trim_q;
         end
         `CMD_PROT_WINDOW: begin
            rd_word[`LEVEL_LSB+:`LEVEL_W]   = protection_margin_level_q;
            rd_word[`FIXED_ONE_LO_BIT]      = 1'b1;
            rd_word[`OV_TRIM_LSB+:`FTRIM_W] = overvolt_factory_trim_q;
            rd_word[`FIXED_ONE_HI_BIT]      = 1'b1;
            rd_word[`UV_TRIM_LSB+:`FTRIM_W] = undervolt_factory_trim_q;
         end
         `CMD_REMOTE_AMP_OFFSET: begin
            rd_word[`AMP_TRIM_W-1:0] = remote_amp_trim_q;
         end
         `CMD_FEEDBACK_GAIN: begin
            rd_word[`GAIN_W-1:0] = feedback_digital_gain_q;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // Read answer and error pulse, one cycle after the strobe.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q   <= 16'h0000;
         rd_valid_q  <= 1'b0;
         cmd_error_q <= 1'b0;
      end else begin
         rd_valid_q  <= rd_en;
         cmd_error_q <= (rd_en || wr_en) && !map_hit;
         if (rd_en) begin
            rd_data_q <= rd_word;
         end
      end
   end

   // Decoded level; the top bit says whether the code is legal.
   always_comb begin
      margin_dec = margin_decode(protection_margin_level_q);
   end

   // Effective margin only follows the level field while its code is legal.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         margin_mv_q           <= `MARGIN_190_MV;
         margin_code_invalid_q <= 1'b0;
      end else begin
         margin_code_invalid_q <= !margin_dec[`MV_W];
         if (margin_dec[`MV_W]) begin
            margin_mv_q <= margin_dec[`MV_W-1:0];
         end
      end
   end

   // Thresholds around the reference; half gain doubles the margin.
   always_comb begin
      code_known = (sense_amp_gain_select == vout_sense_pkg::amp_half);
      margin_eff = code_known ? {margin_mv_q[`MV_W-2:0], 1'b0} : margin_mv_q;
      ov_sum     = {1'b0, vref_mv} + {1'b0, margin_eff};
      // Clamping at zero keeps a low reference from wrapping to a huge limit.
      uv_diff    = (vref_mv > margin_eff) ? (vref_mv - margin_eff) : '0;
   end

   // Limits are registered; the upper one saturates at full scale.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         secondary_overvoltage_limit_q  <= '0;
         secondary_undervoltage_limit_q <= '0;
      end else begin
         secondary_overvoltage_limit_q  <= ov_sum[`MV_W] ? {`MV_W{1'b1}} : ov_sum[`MV_W-1:0];
         secondary_undervoltage_limit_q <= uv_diff;
      end
   end

   // Signed trim products in physical units for the analog side.
   always_comb begin
      amp_step   = sense_amp_gain_select ? `AMP_STEP_HALF_UV : `AMP_STEP_UNITY_UV;
      // Both factors are widened first so the product cannot overflow a narrow operand.
      droop_prod = 20'(signed'(droop_current_trim_q)) * 20'(signed'({1'b0, `DROOP_STEP_NA}));
      amp_prod   = 20'(signed'(remote_amp_trim_q)) * 20'(signed'({1'b0, amp_step}));
   end

   // Registering the products keeps the wide multipliers off the output path.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         droop_offset_na_q      <= '0;
         remote_amp_offset_uv_q <= '0;
         remote_amp_step_uv_q   <= `AMP_STEP_UNITY_UV;
      end else begin
         droop_offset_na_q      <= droop_prod;
         remote_amp_offset_uv_q <= amp_prod;
         remote_amp_step_uv_q   <= amp_step;
      end
   end

   // Feedback scaling for the DC loop.
   feedback_scaler u_scaler (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .sample_valid   (sample_valid),
      .sample         (feedback_raw_sample),
      .gain           (feedback_digital_gain_q),
      .scaled_q       (scaled_feedback_value_q),
      .scaled_valid_q (scaled_valid_q)
   );

endmodule

// ==== rtl/vout_sense_trim_regs.svh ====
// Purpose: Command codes, field layouts, reset values and scaling constants
//          for the output-voltage sense trim register bank.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Types live in vout_sense_pkg; only defines are kept here.
//
// Notes on behaviour
// - Unused bits ignore writes, read as zero.
// - Droop trim: 6-bit signed, 0.81 uA steps.
// - Margin codes 001/010/100 give 190/310/430 mV.
// - Unity gain: limits at reference plus/minus margin.
// - Half gain: limits use twice the margin.
// - Remote amp trim: 7-bit signed output offset.
// - Amp trim step 0.5 mV unity, 0.8 mV half.
// - Scaled feedback is sample times gain over 1024.
// - Feedback gain resets to 1024, unity scaling.
// - Gain select bit: 0 unity, 1 half.
`ifndef VOUT_SENSE_TRIM_REGS_SVH
`define VOUT_SENSE_TRIM_REGS_SVH

// Command codes of the four registers.
`define CMD_DROOP_OFFSET      8'h2b
`define CMD_PROT_WINDOW       8'h2c
`define CMD_REMOTE_AMP_OFFSET 8'h2d
`define CMD_FEEDBACK_GAIN     8'h2e

// Field widths and positions.
`define DROOP_TRIM_W          6
`define AMP_TRIM_W            7
`define GAIN_W                11
`define LEVEL_W               3
`define FTRIM_W               2
`define LEVEL_LSB             0
`define FIXED_ONE_LO_BIT      3
`define OV_TRIM_LSB           4
`define FIXED_ONE_HI_BIT      6
`define UV_TRIM_LSB           7
`define SAMPLE_W              12
`define MV_W                  14

// Reset values.
`define DROOP_TRIM_RST        6'h00
`define AMP_TRIM_RST          7'h00
`define GAIN_RST              11'h400
`define LEVEL_RST             3'h1
`define OV_TRIM_RST           2'h0
`define UV_TRIM_RST           2'h0

// Margin codes and their margins in millivolts.
`define LEVEL_CODE_190        3'h1
`define LEVEL_CODE_310        3'h2
`define LEVEL_CODE_430        3'h4
`define MARGIN_190_MV         14'h00be
`define MARGIN_310_MV         14'h0136
`define MARGIN_430_MV         14'h01ae

// Scaling: trim steps in nanoamps and microvolts, gain divide by 1024.
`define DROOP_STEP_NA         10'h32a
`define AMP_STEP_UNITY_UV     10'h1f4
`define AMP_STEP_HALF_UV      10'h320
`define GAIN_SHIFT            10

`endif

// ==== sim/mgmt_host_model.sv ====
// Purpose: Management host that issues one-cycle register strobes.
// Assumes: Strobes change on the falling edge and are taken at the next rising edge.
// Notes:   Window writes merge back the factory trims that a read returned.
`timescale 1ns/10ps
module mgmt_host_model (
   input  logic        ref_clk,
   input  logic [15:0] rd_data_q,
   output logic        wr_en,
   output logic        rd_en,
   output logic [7:0]  cmd_code,
   output logic [15:0] wr_data
);
   // Idle bus from time zero.
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      cmd_code = 8'h00;
      wr_data = 16'h0000;
   end
   // Released data is inverted so a late sample cannot pass for a match.
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge ref_clk);
      wr_en = 1'b1;
      cmd_code = c;
      wr_data = d;
      @(negedge ref_clk);
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Read data is taken once the strobe edge has landed.
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(negedge ref_clk);
      rd_en = 1'b1;
      cmd_code = c;
      @(negedge ref_clk);
      rd_en = 1'b0;
      d = rd_data_q;
   endtask
   // Factory trim bits are carried over untouched.
   task automatic set_level(input logic [2:0] lv);
      logic [15:0] cur;
      rd(8'h2c, cur);
      wr(8'h2c, (cur & 16'h01b0) | {13'h0000, lv});
   endtask
endmodule

// ==== sim/vout_sense_trim_regs_asserts.sv ====
// Purpose: Port-level checker for the sense trim register bank.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Limits are judged only once the margin code has been steady for three edges.
`include "vout_sense_trim_regs.svh"
`timescale 1ns/10ps
module vout_sense_trim_regs_asserts (
   input logic        ref_clk,
   input logic        resetn,
   input logic        wr_en,
   input logic        rd_en,
   input logic [7:0]  cmd_code,
   input logic [15:0] wr_data,
   input logic        sense_amp_gain_select,
   input logic [13:0] vref_mv,
   input logic        sample_valid,
   input logic [11:0] feedback_raw_sample,
   input logic [15:0] rd_data_q,
   input logic        rd_valid_q,
   input logic [5:0]  droop_current_trim_q,
   input logic [19:0] droop_offset_na_q,
   input logic [9:0]  remote_amp_step_uv_q,
   input logic [10:0] feedback_digital_gain_q,
   input logic [2:0]  protection_margin_level_q,
   input logic        margin_code_invalid_q,
   input logic [13:0] secondary_overvoltage_limit_q,
   input logic [13:0] secondary_undervoltage_limit_q,
   input logic [11:0] scaled_feedback_value_q,
   input logic        scaled_valid_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Bits that must read as zero for each command code.
   function automatic logic [15:0] zmask(logic [7:0] c);
      case (c)
         `CMD_DROOP_OFFSET: return 16'hffc0;
         `CMD_PROT_WINDOW: return 16'hfe00;
         `CMD_REMOTE_AMP_OFFSET: return 16'hff80;
         `CMD_FEEDBACK_GAIN: return 16'hf800;
         default: return 16'hffff;
      endcase
   endfunction

   // Expected limit; widened by one bit so overflow and underflow are seen.
   function automatic logic [13:0] lim(logic up, logic [2:0] lv, logic hs, logic [13:0] v);
      logic [14:0] m;
      logic [14:0] s;
      m = (lv == 3'h1) ? 15'h00be : (lv == 3'h2) ? 15'h0136 : 15'h01ae;
      m = m << hs;
      s = up ? {1'b0, v} + m : {1'b0, v} - m;
      if (up) return s[14] ? 14'h3fff : s[13:0];
      return ({1'b0, v} < m) ? 14'h0000 : s[13:0];
   endfunction

   // Expected scaled sample, truncated and saturated at the sample width.
   function automatic logic [11:0] scl(logic [11:0] s, logic [10:0] g);
      logic [22:0] p;
      p = ({11'h000, s} * {12'h000, g}) >> 10;
      return (p > 23'h000fff) ? 12'hfff : p[11:0];
   endfunction

   property p_droop_wr;
      wr_en && cmd_code == `CMD_DROOP_OFFSET |=> droop_current_trim_q == $past(wr_data[5:0]);
   endproperty
   a_droop_wr: assert property (p_droop_wr)
      else $error("droop trim field not written");
   property p_droop_na;
      $stable(droop_current_trim_q)[*2]
         |-> droop_offset_na_q == 20'({{14{droop_current_trim_q[5]}}, droop_current_trim_q} * 20'h0032a);
   endproperty
   a_droop_na: assert property (p_droop_na)
      else $error("droop offset product wrong");
   property p_gain_wr;
      wr_en && cmd_code == `CMD_FEEDBACK_GAIN |=> feedback_digital_gain_q == $past(wr_data[10:0]);
   endproperty
   a_gain_wr: assert property (p_gain_wr)
      else $error("gain field not written");
   property p_amp_step;
      1'b1 |=> remote_amp_step_uv_q == ($past(sense_amp_gain_select) ? 10'h320 : 10'h1f4);
   endproperty
   a_amp_step: assert property (p_amp_step)
      else $error("amp trim step wrong for gain");
   property p_limits;
      ($stable(protection_margin_level_q) && $stable(vref_mv) && $stable(sense_amp_gain_select)
         && protection_margin_level_q inside {3'h1, 3'h2, 3'h4})[*3]
      |-> secondary_overvoltage_limit_q ==
             lim(1'b1, protection_margin_level_q, sense_amp_gain_select, vref_mv)
          && secondary_undervoltage_limit_q ==
             lim(1'b0, protection_margin_level_q, sense_amp_gain_select, vref_mv);
   endproperty
   a_limits: assert property (p_limits)
      else $error("protection limits wrong");
   property p_scaled;
      sample_valid && $stable(feedback_digital_gain_q) |=> scaled_valid_q
         && scaled_feedback_value_q == scl($past(feedback_raw_sample), $past(feedback_digital_gain_q));
   endproperty
   a_scaled: assert property (p_scaled)
      else $error("scaled feedback wrong");
   property p_rd_mask;
      rd_en |=> rd_valid_q && (rd_data_q & zmask($past(cmd_code))) == 16'h0000;
   endproperty
   a_rd_mask: assert property (p_rd_mask)
      else $error("unused read bits not zero");
   property p_invalid;
      wr_en && cmd_code == `CMD_PROT_WINDOW && !(wr_data[2:0] inside {3'h1, 3'h2, 3'h4})
         |=> ##1 margin_code_invalid_q;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("invalid margin code not flagged");
endmodule
bind vout_sense_trim_regs vout_sense_trim_regs_asserts chk (.*);

// ==== sim/vout_sense_trim_regs_test.sv ====
// Purpose: Self-checking bench for the sense trim register bank.
// Assumes: Inputs change on the falling edge; the host model owns the strobes.
// Notes:   Reference held at 1000 mV so no limit saturates.
`include "vout_sense_trim_regs.svh"
`timescale 1ns/10ps
module vout_sense_trim_regs_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic sense_amp_gain_select = 1'b0;
   logic [13:0] vref_mv = 14'h03e8;
   logic sample_valid = 1'b0;
   logic [11:0] feedback_raw_sample = 12'h000;
   logic wr_en, rd_en, rd_valid_q, cmd_error_q, margin_code_invalid_q, scaled_valid_q;
   logic [7:0] cmd_code;
   logic [15:0] wr_data, rd_data_q;
   logic [5:0] droop_current_trim_q;
   logic [6:0] remote_amp_trim_q;
   logic [9:0] remote_amp_step_uv_q;
   logic [10:0] feedback_digital_gain_q;
   logic [2:0] protection_margin_level_q;
   logic [19:0] droop_offset_na_q, remote_amp_offset_uv_q;
   logic [13:0] secondary_overvoltage_limit_q, secondary_undervoltage_limit_q;
   logic [11:0] scaled_feedback_value_q;
   int miscompares = 0;
   int tests_run = 0;
   logic [7:0] cmd_tab [4] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e};
   logic [15:0] rst_tab [4] = '{16'h0000, 16'h0049, 16'h0000, 16'h0400};
   logic [15:0] full_tab [4] = '{16'h003f, 16'h0000, 16'h007f, 16'h07ff};
   logic [2:0] lv_tab [3] = '{3'h1, 3'h2, 3'h4};
   logic [13:0] mv_tab [3] = '{14'h00be, 14'h0136, 14'h01ae};
   logic [10:0] g_tab [3] = '{11'h200, 11'h7ff, 11'h401};
   logic [11:0] s_tab [3] = '{12'h3e8, 12'hfff, 12'h3ff};
   logic [11:0] e_tab [3] = '{12'h1f4, 12'hfff, 12'h3ff};

   vout_sense_trim_regs uut (.*);
   mgmt_host_model host (.ref_clk(ref_clk), .rd_data_q(rd_data_q), .wr_en(wr_en),
      .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data));

   // Free-running clock at 250 MHz.
   always #2 ref_clk = ~ref_clk;

   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Reset values, then all-ones writes to see unused bits dropped; the window is skipped.
   task automatic t_regs;
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         host.rd(cmd_tab[i], d);
         check(d, rst_tab[i]);
         check(cmd_error_q, 20'h00000);
         if (i != 1) begin
            host.wr(cmd_tab[i], 16'hffff);
            host.rd(cmd_tab[i], d);
            check(d, full_tab[i]);
         end
      end
      host.wr(8'h2f, 16'hffff);
      check(cmd_error_q, 20'h00001);
      host.rd(8'h2f, d);
      check(cmd_error_q, 20'h00001);
      check(d, 20'h00000);
   endtask
   // Most negative amp trim at both gains; droop trim is left at minus one.
   task automatic t_trims;
      host.wr(`CMD_REMOTE_AMP_OFFSET, 16'h0040);
      repeat (3) @(negedge ref_clk);
      check(remote_amp_trim_q, 20'h00040);
      check(droop_offset_na_q, 20'hffcd6);
      check(remote_amp_offset_uv_q, 20'hf8300);
      sense_amp_gain_select = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(remote_amp_offset_uv_q, 20'hf3800);
   endtask
   // Every margin code at half then unity gain, then an invalid code.
   task automatic t_margins;
      logic [15:0] d;
      for (int i = 0; i < 6; i++) begin
         host.set_level(lv_tab[i % 3]);
         sense_amp_gain_select = (i < 3);
         repeat (4) @(negedge ref_clk);
         check(secondary_overvoltage_limit_q, 14'h03e8 + (mv_tab[i % 3] << (i < 3)));
         check(secondary_undervoltage_limit_q, 14'h03e8 - (mv_tab[i % 3] << (i < 3)));
      end
      host.set_level(3'h3);
      repeat (4) @(negedge ref_clk);
      check(margin_code_invalid_q, 20'h00001);
      check(secondary_overvoltage_limit_q, 20'h00596);
      host.rd(`CMD_PROT_WINDOW, d);
      check(d, 20'h0004b);
   endtask
   // Gain below, above and just over unity, including saturation.
   task automatic t_scale;
      for (int i = 0; i < 3; i++) begin
         host.wr(`CMD_FEEDBACK_GAIN, {5'h00, g_tab[i]});
         @(negedge ref_clk);
         sample_valid = 1'b1;
         feedback_raw_sample = s_tab[i];
         @(negedge ref_clk);
         sample_valid = 1'b0;
         check(scaled_valid_q, 20'h00001);
         check(scaled_feedback_value_q, e_tab[i]);
      end
   endtask

   initial begin
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
      t_regs;
      t_trims;
      t_margins;
      t_scale;
      wrap_up;
   end
   // Watchdog well beyond the roughly 120 cycles the tests take.
   initial begin
      #20000;
      miscompares++;
      wrap_up;
   end
endmodule
